// ### hdl/erxtc_pkg.sv
package erxtc_pkg;
    // receive user-bus segment, one beat of a packet
    localparam int ERXTC_DW = 32;
    typedef struct packed {
        logic [ERXTC_DW-1:0] data; // payload word
        logic sop;                 // first word of packet
        logic eop;                 // last word of packet
        logic err;                 // mac flagged error
    } erxtc_beat_t;
    localparam int ERXTC_BEAT_W = ERXTC_DW + 3;

    // test traffic shape, must match the companion generator
    localparam int ERXTC_PKT_COUNT = 16;
    localparam int ERXTC_PKT_BYTES = 522;
    localparam int ERXTC_WORD_BYTES = ERXTC_DW / 8;
    // words per packet incl. fcs word when fcs stays in the frame
    localparam int ERXTC_PKT_WORDS =
        (ERXTC_PKT_BYTES + ERXTC_WORD_BYTES - 1) / ERXTC_WORD_BYTES;
    localparam int ERXTC_PTP_PKTS = 3;
    localparam logic [31:0] ERXTC_DATA_SEED = 32'h0000_0000;

    // fifo shape
    localparam int ERXTC_FIFO_DEPTH = 8;

    // pause control values: accept pause and all priority pause
    localparam logic [8:0] ERXTC_PAUSE_EN_ALL = 9'h1_ff;
    localparam logic [8:0] ERXTC_PAUSE_EN_OFF = 9'h0_00;

    typedef enum logic [3:0] {
        ERXTC_IDLE,
        ERXTC_XCVR_LOCKED,
        ERXTC_WAIT_ALIGN,
        ERXTC_XFER_INIT,
        ERXTC_RECEIVING,
        ERXTC_RX_DONE,
        ERXTC_PTP_RX,
        ERXTC_PTP_DONE,
        ERXTC_WAIT_RESTART
    } erxtc_state_t;

    // indicator bundle towards leds and the mac
    typedef struct packed {
        logic lock;
        logic aligned;
        logic busy;
        logic done;
        logic mismatch;
        logic rx_enable;
    } erxtc_ind_t;
endpackage

// ### hdl/erxtc_fifo.sv
`timescale 1ns/100ps
module erxtc_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk_in,           // system clock
    input wire logic sys_rst_in,           // sync reset, high
    input wire logic [WIDTH-1:0] wr_data_in, // fill data
    input wire logic wr_valid_in,          // fill valid
    output logic wr_ready_out,             // room available
    output logic [WIDTH-1:0] rd_data_out,  // drain data
    output logic rd_valid_out,             // data available
    input wire logic rd_ready_in           // drain accepts
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic do_wr, do_rd;

    // pointers carry one extra bit to tell full from empty
    always_comb begin
        do_wr = wr_valid_in && wr_ready_out;
        do_rd = rd_valid_out && rd_ready_in;
        next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // storage has no reset; contents are qualified by pointers
    always_ff @(posedge ref_clk_in) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= wr_data_in;
        end
    end

    always_comb begin
        wr_ready_out = !((wr_ptr[AW] != rd_ptr[AW]) &&
                         (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
        rd_valid_out = (wr_ptr != rd_ptr);
        rd_data_out = mem[rd_ptr[AW-1:0]];
    end
endmodule

// ### hdl/erxtc_checker.sv
`timescale 1ns/100ps
// Notes on behaviour
// - after reset sit idle, go to xcvr-locked when init completes.
// - xcvr-locked drives lock, busy and rx enable high, then waits align.
// - wait-align holds until lanes aligned is 1, then goes to init.
// - init sets aligned and busy, clears counters, starts receiving.
// - each word taken while receiving is compared with the expected one; miss sets flag.
// - the mismatch flag clears only on a restart request.
// - after the set packet count, receiving ends in rx-done.
// - rx-done clears counters, sets done, waits flow test if both fc on and no one-step.
// - with one-step timestamping rx-done goes to timestamp receiving.
// - timestamp receiving takes three packets, then timestamp-done.
// - timestamp-done only reports, waiting flow test if both fc on.
// - wait-restart clears busy and returns to init on restart edge.
// - lanes falling out of alignment return any state after wait-align to idle.
// - with rx flow control, pause and priority pause are accepted.
// - without fcs stripping, the last word is checked against a table.
module erxtc_checker
    import erxtc_pkg::*;
#(
    parameter int PKT_COUNT = erxtc_pkg::ERXTC_PKT_COUNT,
    parameter int PKT_WORDS = erxtc_pkg::ERXTC_PKT_WORDS,
    parameter logic [31:0] DATA_SEED = erxtc_pkg::ERXTC_DATA_SEED,
    parameter bit RX_FLOW_CTRL = 1'b0,
    parameter bit TX_FLOW_CTRL = 1'b0,
    parameter bit PTP_ONE_STEP = 1'b0,
    parameter bit FCS_KEPT = 1'b0
) (
    input wire logic ref_clk_in,                   // 50 mhz clock
    input wire logic sys_rst_in,                   // sync reset, high
    input wire logic init_done_in,                 // core reset complete
    input wire logic rx_aligned_in,                // mac lanes aligned
    input wire logic restart_in,                   // test restart request
    input wire logic flow_test_done_in,            // pause test finished
    input wire erxtc_pkg::erxtc_beat_t rx_beat_in, // mac rx word
    input wire logic rx_valid_in,                  // rx word valid
    output logic rx_ready_out,                     // fifo has room
    output erxtc_pkg::erxtc_ind_t ind_out,         // indicators
    output logic [8:0] rx_pause_en_out,            // mac pause accept
    output logic [1:0] ptp_count_out               // timestamp pkts seen
);
    import erxtc_pkg::*;

    erxtc_beat_t beat;
    logic [ERXTC_BEAT_W-1:0] beat_bits;
    logic beat_valid, beat_ready, fifo_wr_ready;

    // fifo buffers the mac so a slow compare can stall intake
    erxtc_fifo #(.WIDTH(ERXTC_BEAT_W), .DEPTH(ERXTC_FIFO_DEPTH)) u_fifo (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .wr_data_in(rx_beat_in),
        .wr_valid_in(rx_valid_in),
        .wr_ready_out(fifo_wr_ready),
        .rd_data_out(beat_bits),
        .rd_valid_out(beat_valid),
        .rd_ready_in(beat_ready)
    );
    assign beat = erxtc_beat_t'(beat_bits);

    // expected payload word from packet and word index
    function automatic logic [31:0] exp_word(input logic [15:0] pkt,
                                             input logic [15:0] wrd);
        exp_word = DATA_SEED ^ {pkt, wrd};
    endfunction

    // stand-in fcs table: one value per packet index
    function automatic logic [31:0] fcs_entry(input logic [15:0] pkt);
        fcs_entry = ~exp_word(pkt, 16'hffff);
    endfunction

    erxtc_state_t state, next_state;
    erxtc_ind_t ind, next_ind;
    logic [15:0] pkt_cnt, next_pkt_cnt, word_cnt, next_word_cnt;
    logic [1:0] ptp_cnt, next_ptp_cnt;
    logic restart_q, next_restart_q, restart_rise;
    logic [8:0] pause_en, next_pause_en;
    logic rx_ready, next_rx_ready;
    logic both_fc, take, word_bad, fcs_word;

    always_comb begin
        both_fc = RX_FLOW_CTRL && TX_FLOW_CTRL;
        restart_rise = restart_in && !restart_q;
        beat_ready = (state == ERXTC_RECEIVING) ||
                     (state == ERXTC_PTP_RX) ||
                     (state == ERXTC_WAIT_RESTART) ||
                     (state == ERXTC_RX_DONE);
        take = beat_valid && beat_ready;
        fcs_word = FCS_KEPT && (word_cnt == 16'(PKT_WORDS - 1));
        if (fcs_word) begin
            word_bad = beat.data != fcs_entry(pkt_cnt);
        end else begin
            word_bad = beat.data != exp_word(pkt_cnt, word_cnt);
        end
        word_bad = word_bad || beat.err ||
                   (beat.eop != (word_cnt == 16'(PKT_WORDS - 1)));
    end

    // next state and indicators; one process for the whole fsm
    always_comb begin
        next_state = state;
        next_ind = ind;
        next_pkt_cnt = pkt_cnt;
        next_word_cnt = word_cnt;
        next_ptp_cnt = ptp_cnt;
        next_restart_q = restart_in;
        next_rx_ready = fifo_wr_ready;
        // pause accept set once and held while flow control is on
        next_pause_en = RX_FLOW_CTRL ? ERXTC_PAUSE_EN_ALL
                                     : ERXTC_PAUSE_EN_OFF;
        case (state)
            ERXTC_IDLE: begin
                if (init_done_in) begin
                    next_state = ERXTC_XCVR_LOCKED;
                end
            end
            ERXTC_XCVR_LOCKED: begin
                next_ind.lock = 1'b1;
                next_ind.busy = 1'b1;
                next_ind.rx_enable = 1'b1;
                next_state = ERXTC_WAIT_ALIGN;
            end
            ERXTC_WAIT_ALIGN: begin
                if (rx_aligned_in) begin
                    next_state = ERXTC_XFER_INIT;
                end
            end
            ERXTC_XFER_INIT: begin
                next_ind.aligned = 1'b1;
                next_ind.busy = 1'b1;
                next_ind.done = 1'b0;
                next_pkt_cnt = '0;
                next_word_cnt = '0;
                next_ptp_cnt = '0;
                next_state = ERXTC_RECEIVING;
            end
            ERXTC_RECEIVING: begin
                if (take) begin
                    if (word_bad) begin
                        next_ind.mismatch = 1'b1;
                    end
                    if (beat.eop) begin
                        next_word_cnt = '0;
                        next_pkt_cnt = pkt_cnt + 16'h0001;
                        if (pkt_cnt == 16'(PKT_COUNT - 1)) begin
                            next_state = ERXTC_RX_DONE;
                        end
                    end else begin
                        next_word_cnt = word_cnt + 16'h0001;
                    end
                end
            end
            ERXTC_RX_DONE: begin
                next_pkt_cnt = '0;
                next_word_cnt = '0;
                next_ind.done = 1'b1;
                if (PTP_ONE_STEP) begin
                    next_state = ERXTC_PTP_RX;
                end else if (!both_fc || flow_test_done_in) begin
                    next_state = ERXTC_WAIT_RESTART;
                end
            end
            ERXTC_PTP_RX: begin
                // timestamp frames are counted, content is core-modified
                if (take && beat.eop) begin
                    next_ptp_cnt = ptp_cnt + 2'b01;
                    if (ptp_cnt == 2'(ERXTC_PTP_PKTS - 1)) begin
                        next_state = ERXTC_PTP_DONE;
                    end
                end
            end
            ERXTC_PTP_DONE: begin
                if (!both_fc || flow_test_done_in) begin
                    next_state = ERXTC_WAIT_RESTART;
                end
            end
            ERXTC_WAIT_RESTART: begin
                next_ind.busy = 1'b0;
                next_pkt_cnt = '0;
                next_word_cnt = '0;
                if (restart_rise && rx_aligned_in) begin
                    next_state = ERXTC_XFER_INIT;
                end
            end
            default: begin
                next_state = ERXTC_IDLE;
            end
        endcase
        // only a restart request clears the sticky miss flag
        if (restart_in) begin
            next_ind.mismatch = 1'b0;
        end
        if (state != ERXTC_IDLE && state != ERXTC_XCVR_LOCKED &&
            state != ERXTC_WAIT_ALIGN && !rx_aligned_in) begin
            next_state = ERXTC_IDLE;
            next_ind.aligned = 1'b0;
            next_ind.busy = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state <= ERXTC_IDLE;
            ind <= '0;
            pkt_cnt <= '0;
            word_cnt <= '0;
            ptp_cnt <= '0;
            restart_q <= 1'b0;
            pause_en <= ERXTC_PAUSE_EN_OFF;
            rx_ready <= 1'b0;
        end else begin
            state <= next_state;
            ind <= next_ind;
            pkt_cnt <= next_pkt_cnt;
            word_cnt <= next_word_cnt;
            ptp_cnt <= next_ptp_cnt;
            restart_q <= next_restart_q;
            pause_en <= next_pause_en;
            rx_ready <= next_rx_ready;
        end
    end

    // registered outputs; ready lags fifo by one, fifo keeps real guard
    always_comb begin
        ind_out = ind;
        rx_pause_en_out = pause_en;
        ptp_count_out = ptp_cnt;
        rx_ready_out = rx_ready;
    end

    idle_to_locked_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state == ERXTC_IDLE && init_done_in |=> state == ERXTC_XCVR_LOCKED)
        else $error("idle did not advance on init done");
    locked_leds_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state == ERXTC_XCVR_LOCKED |=> ind.lock && ind.rx_enable && ind.busy)
        else $error("locked state indicators wrong");
    align_wait_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state == ERXTC_WAIT_ALIGN && !rx_aligned_in |=>
        state == ERXTC_WAIT_ALIGN)
        else $error("left align wait too early");
    init_to_rx_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state == ERXTC_XFER_INIT && rx_aligned_in |=>
        state == ERXTC_RECEIVING && ind.aligned && pkt_cnt == 16'h0000)
        else $error("init did not start receiving");
    miss_sets_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state == ERXTC_RECEIVING && take && word_bad && !restart_in |=>
        ind.mismatch)
        else $error("mismatch not flagged");
    miss_sticky_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        ind.mismatch && !restart_in |=> ind.mismatch)
        else $error("mismatch cleared without restart");
    count_done_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state == ERXTC_RECEIVING && rx_aligned_in && take && beat.eop &&
        pkt_cnt == 16'(PKT_COUNT - 1) |=> state == ERXTC_RX_DONE)
        else $error("receive did not end at packet count");
    done_led_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state == ERXTC_RX_DONE |=> ind.done)
        else $error("done indicator not set");
    restart_busy_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state == ERXTC_WAIT_RESTART ##1 state == ERXTC_WAIT_RESTART |->
        !ind.busy)
        else $error("busy high while waiting restart");
    lost_align_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state == ERXTC_RECEIVING && !rx_aligned_in |=> state == ERXTC_IDLE)
        else $error("lost alignment not handled");
    ptp_branch_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state == ERXTC_RX_DONE && rx_aligned_in && PTP_ONE_STEP |=>
        state == ERXTC_PTP_RX)
        else $error("one-step did not enter timestamp receive");
    ptp_count_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state == ERXTC_PTP_RX && rx_aligned_in && take && beat.eop &&
        ptp_cnt == 2'(ERXTC_PTP_PKTS - 1) |=> state == ERXTC_PTP_DONE)
        else $error("timestamp receive did not end at three");
    ptp_flow_hold_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state == ERXTC_PTP_DONE && both_fc && !flow_test_done_in &&
        rx_aligned_in |=> state == ERXTC_PTP_DONE)
        else $error("timestamp done left before flow test");
    rx_done_hold_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state == ERXTC_RX_DONE && !PTP_ONE_STEP && both_fc &&
        !flow_test_done_in && rx_aligned_in |=> state == ERXTC_RX_DONE)
        else $error("rx done left before flow test");
    pause_accept_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state != ERXTC_IDLE |->
        pause_en == (RX_FLOW_CTRL ? ERXTC_PAUSE_EN_ALL : ERXTC_PAUSE_EN_OFF))
        else $error("pause accept setting wrong");
    fcs_check_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        state == ERXTC_RECEIVING && take && fcs_word && !restart_in &&
        beat.data != fcs_entry(pkt_cnt) |=> ind.mismatch)
        else $error("bad fcs word not flagged");
endmodule

// ### verification/erxtc_mac_model.sv
`timescale 1ns/100ps
// far-side mac model: streams test packets whenever room is shown and no stall is asked
module erxtc_mac_model
    import erxtc_pkg::*;
#(
    parameter int PKT_WORDS = 131,
    parameter logic [31:0] SEED = 32'h0000_0000,
    parameter bit FCS_KEPT = 1'b0,  // last word carries the fcs
    parameter int BAD_W = 3         // word index that gets corrupted
) (
    input wire logic ref_clk_in,             // clock
    input wire logic sys_rst_in,             // sync reset, high
    input wire logic go_in,                  // start a burst
    input wire logic [3:0] n_pkts_in,        // packets in burst
    input wire logic [3:0] bad_pkt_in,       // packet with a bad word
    input wire logic stall_in,               // hold back this cycle
    input wire logic ready_in,               // checker has room
    output erxtc_pkg::erxtc_beat_t beat_out, // word on the bus
    output logic valid_out,                  // word valid
    output logic busy_out                    // burst in progress
);
    int p;
    int w;
    int n;
    logic [31:0] cyc;

    // valid only while room is shown; shown room lags the fifo, so a word can be dropped
    assign valid_out = busy_out && !stall_in && (ready_in === 1'b1);

    // idle lines toggle every cycle so stale data never passes as good
    always_comb begin
        if (busy_out) begin
            // stand-in fcs word mirrors the table the checker holds
            if (FCS_KEPT && w == PKT_WORDS - 1)
                beat_out.data = ~(SEED ^ {p[15:0], 16'hffff});
            else
                beat_out.data = SEED ^ {p[15:0], w[15:0]};
            if (p == int'(bad_pkt_in) && w == BAD_W)
                beat_out.data[0] = ~beat_out.data[0];
            beat_out.sop = (w == 0);
            beat_out.eop = (w == PKT_WORDS - 1);
            beat_out.err = 1'b0;
        end else begin
            beat_out = {~cyc, cyc[2:0]};
        end
    end

    // packets go back to back, eop on the last word of each
    always_ff @(posedge ref_clk_in) begin
        cyc <= sys_rst_in ? 32'h0000_0000 : cyc + 32'h0000_0001;
        if (sys_rst_in) begin
            busy_out <= 1'b0;
            p <= 0;
            w <= 0;
        end else if (go_in && !busy_out) begin
            busy_out <= 1'b1;
            n <= int'(n_pkts_in);
            p <= 0;
            w <= 0;
        end else if (valid_out) begin
            if (w == PKT_WORDS - 1) begin
                w <= 0;
                p <= p + 1;
                if (p == n - 1)
                    busy_out <= 1'b0;
            end else begin
                w <= w + 1;
            end
        end
    end
endmodule

// ### verification/tb.sv
`timescale 1ns/100ps
// self-checking bench for the receive traffic checker
module tb;
    import erxtc_pkg::*;
    localparam int PC = 2; // shortened packet count keeps the run brief
    localparam int LK = 5;
    localparam int AL = 4;
    localparam int BZ = 3;
    localparam int DN = 2;
    localparam int MM = 1;
    localparam int EN = 0;
    logic ref_clk_in, sys_rst_in, init_done, aligned, restart, fdone;
    logic go, stall, kill, m_rst, m_busy, rx_valid, rx_ready;
    logic [3:0] n_pkts, bad_pkt;
    logic [5:0] f;
    logic [8:0] pause_en;
    logic [1:0] ptp_cnt;
    erxtc_beat_t beat;
    erxtc_ind_t ind;
    erxtc_beat_t beat2;
    erxtc_ind_t ind2;
    logic m2_busy, rx_valid2, rx_ready2;
    logic [8:0] pause_en2;
    logic [1:0] ptp_cnt2;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;

    assign m_rst = sys_rst_in | kill;

    erxtc_checker #(.PKT_COUNT(PC), .RX_FLOW_CTRL(1'b1),
        .TX_FLOW_CTRL(1'b1), .PTP_ONE_STEP(1'b1)) dut (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .init_done_in(init_done), .rx_aligned_in(aligned),
        .restart_in(restart), .flow_test_done_in(fdone),
        .rx_beat_in(beat), .rx_valid_in(rx_valid),
        .rx_ready_out(rx_ready), .ind_out(ind),
        .rx_pause_en_out(pause_en), .ptp_count_out(ptp_cnt));

    erxtc_mac_model #(.PKT_WORDS(ERXTC_PKT_WORDS)) mac (
        .ref_clk_in(ref_clk_in), .sys_rst_in(m_rst), .go_in(go),
        .n_pkts_in(n_pkts), .bad_pkt_in(bad_pkt), .stall_in(stall),
        .ready_in(rx_ready), .beat_out(beat), .valid_out(rx_valid),
        .busy_out(m_busy));

    // second build: fcs kept, no timestamping, rx-done waits flow test
    erxtc_checker #(.PKT_COUNT(PC), .RX_FLOW_CTRL(1'b1),
        .TX_FLOW_CTRL(1'b1), .FCS_KEPT(1'b1)) dut2 (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .init_done_in(init_done), .rx_aligned_in(aligned),
        .restart_in(restart), .flow_test_done_in(fdone),
        .rx_beat_in(beat2), .rx_valid_in(rx_valid2),
        .rx_ready_out(rx_ready2), .ind_out(ind2),
        .rx_pause_en_out(pause_en2), .ptp_count_out(ptp_cnt2));

    // its far side corrupts the fcs word instead of a payload word
    erxtc_mac_model #(.PKT_WORDS(ERXTC_PKT_WORDS), .FCS_KEPT(1'b1),
        .BAD_W(ERXTC_PKT_WORDS - 1)) mac2 (
        .ref_clk_in(ref_clk_in), .sys_rst_in(m_rst), .go_in(go),
        .n_pkts_in(n_pkts), .bad_pkt_in(bad_pkt), .stall_in(stall),
        .ready_in(rx_ready2), .beat_out(beat2), .valid_out(rx_valid2),
        .busy_out(m2_busy));

    // 50 mhz clock
    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end

    task automatic finish_test();
        if (n_mismatch == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // random stalls on the far side; a hang is cut short by the ceiling
    always @(posedge ref_clk_in) begin
        cycles++;
        stall <= ($urandom_range(3) == 0);
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask

    // bounded wait for one indicator bit, then compare it
    task automatic wait_ind(input int b, input logic v, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge ref_clk_in);
            #1;
            f = ind;
            if (f[b] === v)
                break;
        end
        f = ind;
        chk(f[b] === v, "indicator did not settle");
    endtask

    // one burst from the far side, waited for under a bound
    task automatic send(input int n, input int bad);
        @(posedge ref_clk_in);
        n_pkts <= 4'(n);
        bad_pkt <= 4'(bad);
        go <= 1'b1;
        @(posedge ref_clk_in);
        go <= 1'b0;
        #1;
        for (int i = 0; i < 3000 && (m_busy !== 1'b0 ||
                                     m2_busy !== 1'b0); i++) begin
            @(posedge ref_clk_in);
            #1;
        end
    endtask

    // ptp burst, then the flow test finishing lets busy fall
    task automatic ptp_and_flow();
        send(3, 15);
        for (int i = 0; i < 20 && ptp_cnt !== 2'h3; i++) begin
            @(posedge ref_clk_in);
            #1;
        end
        chk(ptp_cnt === 2'h3, "ptp count");
        chk(ptp_cnt2 === 2'h0, "ptp taken without one-step");
        repeat (20) @(posedge ref_clk_in);
        #1;
        chk(ind.busy === 1'b1, "left before flow test");
        chk(ind2.done & ind2.busy, "rx done left early");
        @(posedge ref_clk_in);
        fdone <= 1'b1;
        wait_ind(BZ, 1'b0, 6);
        chk(ind2.busy === 1'b0, "rx done ignored flow test");
        @(posedge ref_clk_in);
        fdone <= 1'b0;
    endtask

    initial begin
        void'($urandom(32'h78cf));
        sys_rst_in = 1'b1;
        init_done = 1'b0;
        aligned = 1'b0;
        restart = 1'b0;
        fdone = 1'b0;
        go = 1'b0;
        kill = 1'b0;
        n_pkts = 4'h0;
        bad_pkt = 4'hf;
        repeat (7) @(posedge ref_clk_in);
        #1;
        chk(ind === 6'h00 && pause_en === 9'h000, "reset values");
        @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        aligned <= 1'b1;
        repeat (3 + $urandom_range(7)) @(posedge ref_clk_in);
        #1;
        chk(ind.lock === 1'b0, "left idle without init");
        @(posedge ref_clk_in);
        aligned <= 1'b0;
        init_done <= 1'b1;
        wait_ind(LK, 1'b1, 4);
        chk(ind.busy === 1'b1 && ind.rx_enable === 1'b1, "locked");
        chk(pause_en === 9'h1ff && pause_en2 === 9'h1ff, "pause accept");
        repeat (5 + $urandom_range(9)) @(posedge ref_clk_in);
        #1;
        chk(ind.aligned === 1'b0, "did not wait for lanes");
        @(posedge ref_clk_in);
        aligned <= 1'b1;
        wait_ind(AL, 1'b1, 4);
        chk(ind.busy === 1'b1, "busy in init");
        // clean run: no mismatch, done after the set count
        send(PC, 15);
        wait_ind(DN, 1'b1, 20);
        chk(ind.mismatch === 1'b0, "false mismatch");
        chk(ind2.mismatch === 1'b0 && ind2.done === 1'b1, "fcs miss");
        ptp_and_flow();
        // restart edge while aligned starts a second run
        @(posedge ref_clk_in);
        restart <= 1'b1;
        @(posedge ref_clk_in);
        restart <= 1'b0;
        wait_ind(BZ, 1'b1, 6);
        // corrupt word in the last packet must be caught and kept
        send(PC, PC - 1);
        wait_ind(MM, 1'b1, 6);
        wait_ind(DN, 1'b1, 20);
        chk(ind2.mismatch === 1'b1, "bad fcs not caught");
        ptp_and_flow();
        chk(ind.mismatch === 1'b1, "mismatch lost");
        @(posedge ref_clk_in);
        restart <= 1'b1;
        wait_ind(MM, 1'b0, 4);
        chk(ind2.mismatch === 1'b0, "fcs miss not cleared");
        @(posedge ref_clk_in);
        restart <= 1'b0;
        wait_ind(BZ, 1'b1, 6);
        // lanes drop in mid-packet
        @(posedge ref_clk_in);
        n_pkts <= 4'(PC);
        bad_pkt <= 4'hf;
        go <= 1'b1;
        @(posedge ref_clk_in);
        go <= 1'b0;
        repeat (60) @(posedge ref_clk_in);
        aligned <= 1'b0;
        kill <= 1'b1;
        wait_ind(AL, 1'b0, 4);
        chk(ind.done === 1'b0, "done kept after lanes lost");
        chk(ind2.aligned === 1'b0, "lanes lost ignored");
        finish_test();
    end
endmodule
